// ---- rtl/opv_debounce.sv ----
// two-edge debouncer for the volume push-button
`timescale 1ns/1ps
`default_nettype none
module opv_debounce #(
   parameter int DEB_CYCLES = opv_pkg::DEB_CYC
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic raw_i,
   output logic      level_o,
   output logic      fall_o
);
   typedef struct packed {
      logic        level;
      logic        fall;
      logic [31:0] cnt;
   } opv_deb_t;

   opv_deb_t st_reg;
   opv_deb_t st_next;

   always_comb begin
      st_next      = st_reg;
      st_next.fall = 1'b0;
      // a new level must hold for the full window on either edge
      if (raw_i == st_reg.level) begin
         st_next.cnt = 32'h0000_0000;
      end else if (st_reg.cnt >= 32'(DEB_CYCLES - 1)) begin
         st_next.cnt   = 32'h0000_0000;
         st_next.level = raw_i;
         st_next.fall  = st_reg.level & ~raw_i;
      end else begin
         st_next.cnt = st_reg.cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '{level: 1'b1, fall: 1'b0, cnt: 32'h0000_0000};
      end else begin
         st_reg <= st_next;
      end
   end

   assign level_o = st_reg.level;
   assign fall_o  = st_reg.fall;
endmodule
`default_nettype wire

// ---- rtl/opv_pkg.sv ----
// package: register map, field layout and timing for the output path volume control
package opv_pkg;
   // wishbone word offsets (byte addresses)
   localparam logic [3:0] ADDR_APC    = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_NVCFG  = 4'h8;

   // analog_path_config fields
   localparam int VOL_LSB     = 0;
   localparam int VOL_W       = 3;
   localparam int AUX_MODE_B  = 7;
   localparam int SPK_EN_B    = 8;
   localparam int AUX_PD_B    = 9;
   localparam int APC_W       = 12;

   localparam logic [2:0] VOL_MAX = 3'h7;
   localparam logic [2:0] VOL_MIN = 3'h0;

   // factory defaults: speaker on, current mode (bit 7 low), aux powered (bit 9 low)
   localparam logic [11:0] APC_RESET = 12'h107;
   localparam logic [2:0]  NV_VOL_RESET = 3'h7;

   // status register layout
   localparam int ST_DIR_B    = 3;
   localparam int ST_RAMP_LSB = 8;

   // debounce time and pop ramp time
   localparam int CLK_HZ       = 25_000_000;
   localparam int DEB_US       = 20_000;
   localparam int DEB_CYC      = (CLK_HZ / 1_000_000) * DEB_US;
   localparam int RAMP_STEP_US = 40;
   localparam int RAMP_STEP_CYC = (CLK_HZ / 1_000_000) * RAMP_STEP_US;
   localparam int RAMP_W       = 8;
endpackage

// ---- rtl/opv_ramp.sv ----
// pop-suppressing ramp for the auxiliary current output
`timescale 1ns/1ps
`default_nettype none
module opv_ramp #(
   parameter int W          = opv_pkg::RAMP_W,
   parameter int STEP_CYCLES = opv_pkg::RAMP_STEP_CYC
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         active_i,
   input  wire logic         bypass_i,
   output logic [W-1:0]      level_o
);
   typedef struct packed {
      logic [W-1:0] level;
      logic [15:0]  tick;
   } opv_ramp_t;

   opv_ramp_t st_reg;
   opv_ramp_t st_next;
   logic      step;

   always_comb begin
      st_next = st_reg;
      step    = (st_reg.tick >= 16'(STEP_CYCLES - 1));
      st_next.tick = step ? 16'h0000 : st_reg.tick + 16'h0001;
      if (bypass_i) begin
         // voltage mode has no ramp: jumps straight to target
         st_next.level = active_i ? {W{1'b1}} : '0;
      end else if (step) begin
         if (active_i && st_reg.level != {W{1'b1}}) begin
            st_next.level = st_reg.level + W'(1);
         end else if (!active_i && st_reg.level != '0) begin
            st_next.level = st_reg.level - W'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '{level: '0, tick: 16'h0000};
      end else begin
         st_reg <= st_next;
      end
   end

   assign level_o = st_reg.level;
endmodule
`default_nettype wire

// ---- rtl/opv_top.sv ----
// output path volume control: button stepping, config register, output enables
// How it works
// - eight levels, each button press steps one level
// - sweep down to minimum, back up, repeat
// - reset loads volume from non-volatile setting
// - config bits two to zero set volume
// - button pulled up and debounced both edges
// - speaker outputs released when powered down/unused
// - config bit eight enables speaker, default on
// - config bit seven picks current/voltage, default current
// - config bit nine powers aux down, default off (aux powered)
// - current mode ramps aux up and down
`timescale 1ns/1ps
`default_nettype none
module opv_top #(
   parameter int DEB_CYCLES  = opv_pkg::DEB_CYC,
   parameter int STEP_CYCLES = opv_pkg::RAMP_STEP_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // classic wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   output logic             err_o,
   // push-button, low when pressed; pad pull-up assumed
   input  wire logic        volume_step_input_i,
   // device power and path activity
   input  wire logic        power_down_i,
   input  wire logic        speaker_active_i,
   input  wire logic        aux_active_i,
   input  wire logic        pwm_pos_i,
   input  wire logic        pwm_neg_i,
   // speaker pins
   output logic             speaker_drive_pos_o,
   output logic             speaker_drive_pos_oe_o,
   output logic             speaker_drive_neg_o,
   output logic             speaker_drive_neg_oe_o,
   // auxiliary output controls
   output logic             aux_voltage_mode_o,
   output logic             aux_power_on_o,
   output logic [7:0]       aux_current_output_o,
   output logic [2:0]       volume_level_o
);
   typedef struct packed {
      logic [2:0]  nv_vol;
      logic [2:0]  volume_step_input;
      logic        rising;
      logic [8:0]  apc_hi;
      logic        ack;
      logic        err;
      logic [31:0] rdata;
      logic        spk_pos;
      logic        spk_neg;
      logic        spk_oe;
   } opv_top_t;

   // the non-volatile copy stays out of the reset branch; its power-up value is factory max
   opv_top_t st_reg = '{nv_vol: opv_pkg::NV_VOL_RESET, default: '0};
   opv_top_t st_next;

   logic             btn_level;
   logic             btn_fall;
   logic [7:0]       ramp_level;
   logic             req;
   logic [31:0]      apc_word;
   logic [31:0]      status_word;

   // pull-up is a pad feature; debounce both edges before use
   opv_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .raw_i   (volume_step_input_i),
      .level_o (btn_level),
      .fall_o  (btn_fall)
   );

   opv_ramp #(.W(opv_pkg::RAMP_W), .STEP_CYCLES(STEP_CYCLES)) u_ramp (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .active_i (aux_active_i & aux_power_on_o & ~power_down_i),
      .bypass_i (st_reg.apc_hi[opv_pkg::AUX_MODE_B - opv_pkg::VOL_W]),
      .level_o  (ramp_level)
   );

   assign req = cyc_i & stb_i & ~st_reg.ack & ~st_reg.err;

   always_comb begin
      apc_word = 32'h0000_0000;
      apc_word[opv_pkg::VOL_LSB +: opv_pkg::VOL_W] = st_reg.volume_step_input;
      apc_word[opv_pkg::APC_W-1:opv_pkg::VOL_W]    = st_reg.apc_hi;
      status_word = 32'h0000_0000;
      status_word[opv_pkg::VOL_LSB +: opv_pkg::VOL_W] = st_reg.volume_step_input;
      status_word[opv_pkg::ST_DIR_B] = st_reg.rising;
      status_word[opv_pkg::ST_RAMP_LSB +: opv_pkg::RAMP_W] = ramp_level;
      status_word[opv_pkg::ST_RAMP_LSB + opv_pkg::RAMP_W] = btn_level;
   end

   always_comb begin
      st_next       = st_reg;
      st_next.ack   = 1'b0;
      st_next.err   = 1'b0;

      // button sweep: down to minimum, then up to maximum, forever
      if (btn_fall) begin
         if (!st_reg.rising) begin
            if (st_reg.volume_step_input == opv_pkg::VOL_MIN + 3'h1) begin
               st_next.volume_step_input    = opv_pkg::VOL_MIN;
               st_next.rising = 1'b1;
            end else if (st_reg.volume_step_input == opv_pkg::VOL_MIN) begin
               st_next.volume_step_input    = st_reg.volume_step_input + 3'h1;
               st_next.rising = 1'b1;
            end else begin
               st_next.volume_step_input = st_reg.volume_step_input - 3'h1;
            end
         end else begin
            if (st_reg.volume_step_input == opv_pkg::VOL_MAX - 3'h1) begin
               st_next.volume_step_input    = opv_pkg::VOL_MAX;
               st_next.rising = 1'b0;
            end else if (st_reg.volume_step_input == opv_pkg::VOL_MAX) begin
               st_next.volume_step_input    = st_reg.volume_step_input - 3'h1;
               st_next.rising = 1'b0;
            end else begin
               st_next.volume_step_input = st_reg.volume_step_input + 3'h1;
            end
         end
      end

      // bus access; a register write in the same cycle as a press wins
      if (req) begin
         st_next.ack = 1'b1;
         case (adr_i)
            opv_pkg::ADDR_APC: begin
               if (we_i) begin
                  if (sel_i[0]) begin
                     st_next.volume_step_input = dat_i[opv_pkg::VOL_LSB +: opv_pkg::VOL_W];
                     st_next.apc_hi[7-opv_pkg::VOL_W:0] = dat_i[7:opv_pkg::VOL_W];
                  end
                  if (sel_i[1]) begin
                     st_next.apc_hi[opv_pkg::APC_W-1-opv_pkg::VOL_W:8-opv_pkg::VOL_W] =
                        dat_i[opv_pkg::APC_W-1:8];
                  end
               end
               st_next.rdata = apc_word;
            end
            opv_pkg::ADDR_STATUS: begin
               st_next.rdata = status_word;
            end
            opv_pkg::ADDR_NVCFG: begin
               if (we_i && sel_i[0]) begin
                  st_next.nv_vol = dat_i[opv_pkg::VOL_LSB +: opv_pkg::VOL_W];
               end
               st_next.rdata = 32'h0000_0000;
               st_next.rdata[opv_pkg::VOL_LSB +: opv_pkg::VOL_W] = st_reg.nv_vol;
            end
            default: begin
               st_next.ack   = 1'b0;
               st_next.err   = 1'b1;
               st_next.rdata = 32'h0000_0000;
            end
         endcase
      end

      // speaker released when powered down, disabled, or idle
      st_next.spk_oe  = ~power_down_i & speaker_active_i
                        & st_next.apc_hi[opv_pkg::SPK_EN_B - opv_pkg::VOL_W];
      st_next.spk_pos = st_next.spk_oe & pwm_pos_i;
      st_next.spk_neg = st_next.spk_oe & pwm_neg_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // nv setting survives reset; volume reloads from it
         st_reg.volume_step_input     <= st_reg.nv_vol;
         st_reg.rising  <= 1'b0;
         st_reg.apc_hi  <= opv_pkg::APC_RESET[opv_pkg::APC_W-1:opv_pkg::VOL_W];
         st_reg.ack     <= 1'b0;
         st_reg.err     <= 1'b0;
         st_reg.rdata   <= 32'h0000_0000;
         st_reg.spk_pos <= 1'b0;
         st_reg.spk_neg <= 1'b0;
         st_reg.spk_oe  <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign dat_o                  = st_reg.rdata;
   assign ack_o                  = st_reg.ack;
   assign err_o                  = st_reg.err;
   assign speaker_drive_pos_o    = st_reg.spk_pos;
   assign speaker_drive_neg_o    = st_reg.spk_neg;
   assign speaker_drive_pos_oe_o = st_reg.spk_oe;
   assign speaker_drive_neg_oe_o = st_reg.spk_oe;
   assign aux_voltage_mode_o     = st_reg.apc_hi[opv_pkg::AUX_MODE_B - opv_pkg::VOL_W];
   assign aux_power_on_o         = ~st_reg.apc_hi[opv_pkg::AUX_PD_B - opv_pkg::VOL_W];
   assign aux_current_output_o   = (aux_power_on_o && !aux_voltage_mode_o) ?
                                   ramp_level : 8'h00;
   assign volume_level_o         = st_reg.volume_step_input;
endmodule
`default_nettype wire

// ---- test/opv_button.sv ----
// partner: bouncing push-button with pad pull-up
`timescale 1ns/1ps
`default_nettype none
module opv_button (
   input  wire logic clk_i,
   input  wire logic press_i,
   output var logic  line_o
);
   logic [1:0] bcnt_reg = 2'h0;
   logic       last_reg = 1'b0;
   always_ff @(posedge clk_i) begin
      last_reg <= press_i;
      if (press_i != last_reg) bcnt_reg <= 2'h3;
      else if (bcnt_reg != 2'h0) bcnt_reg <= bcnt_reg - 2'h1;
   end
   // contacts chatter for three cycles after each change; released reads high
   assign line_o = bcnt_reg[0] ? press_i : !press_i;
endmodule
`default_nettype wire

// ---- test/opv_properties.sv ----
// checker: port timing relations of the output path volume control
`timescale 1ns/1ps
`default_nettype none
module opv_properties (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       cyc_i,
   input wire logic       stb_i,
   input wire logic       power_down_i,
   input wire logic       speaker_active_i,
   input wire logic       ack_o,
   input wire logic       err_o,
   input wire logic       speaker_drive_pos_oe_o,
   input wire logic       speaker_drive_neg_oe_o,
   input wire logic       aux_voltage_mode_o,
   input wire logic       aux_power_on_o,
   input wire logic [7:0] aux_current_output_o,
   input wire logic [2:0] volume_level_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req; cyc_i && stb_i && !ack_o && !err_o; endsequence
   sequence s_cur; !aux_voltage_mode_o [*3]; endsequence
   a_bus_answer: assert property (s_req |=> ack_o || err_o) else $error("no answer");
   a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
   a_vol_step: assert property ($changed(volume_level_o) && !ack_o |->
      (volume_level_o - $past(volume_level_o)) inside {3'h1, 3'h7}) else $error("vol jump");
   a_spk_enable: assert property (speaker_drive_pos_oe_o |-> speaker_drive_neg_oe_o
      && $past(speaker_active_i)) else $error("speaker driven while unused");
   a_spk_off: assert property ($past(power_down_i) |-> !speaker_drive_pos_oe_o
      && !speaker_drive_neg_oe_o) else $error("speaker driven in power down");
   a_volt_quiet: assert property (aux_voltage_mode_o [*3] |->
      aux_current_output_o == 8'h00) else $error("current out in voltage mode");
   a_ramp_slope: assert property (s_cur ##0 $changed(aux_current_output_o) |->
      (aux_current_output_o - $past(aux_current_output_o)) inside {8'h01, 8'hff})
      else $error("ramp jump");
   a_reset_state: assert property (disable iff (1'b0) $past(rst_i) |-> !ack_o
      && !err_o && !speaker_drive_pos_oe_o && aux_power_on_o && !aux_voltage_mode_o)
      else $error("bad reset state");
endmodule
bind opv_top opv_properties u_opv_properties (
   .clk_i                  (clk_i),
   .rst_i                  (rst_i),
   .cyc_i                  (cyc_i),
   .stb_i                  (stb_i),
   .power_down_i           (power_down_i),
   .speaker_active_i       (speaker_active_i),
   .ack_o                  (ack_o),
   .err_o                  (err_o),
   .speaker_drive_pos_oe_o (speaker_drive_pos_oe_o),
   .speaker_drive_neg_oe_o (speaker_drive_neg_oe_o),
   .aux_voltage_mode_o     (aux_voltage_mode_o),
   .aux_power_on_o         (aux_power_on_o),
   .aux_current_output_o   (aux_current_output_o),
   .volume_level_o         (volume_level_o)
);
`default_nettype wire

// ---- test/tb.sv ----
// bench: bus, button and path stimulus for the volume control, self-checking
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, press = 0;
   logic [3:0]  adr_i = 4'h0, sel_i = 4'hf;
   logic [31:0] dat_i = 32'h0000_0000, dat_o, q;
   logic        ack_o, err_o, e, volume_step_input_i, pwm_neg_i;
   logic        power_down_i = 0, speaker_active_i = 1, aux_active_i = 0, pwm_pos_i = 0;
   logic        speaker_drive_pos_o, speaker_drive_pos_oe_o, speaker_drive_neg_o;
   logic        speaker_drive_neg_oe_o, aux_voltage_mode_o, aux_power_on_o;
   logic [7:0]  aux_current_output_o;
   logic [2:0]  volume_level_o, v;
   int          n_fail = 0, n_tests = 0;
   // short counts keep the debounce and ramp scenarios brief
   opv_top #(.DEB_CYCLES(4), .STEP_CYCLES(2)) u_opv_top (
      .clk_i                  (clk_i),
      .rst_i                  (rst_i),
      .cyc_i                  (cyc_i),
      .stb_i                  (stb_i),
      .we_i                   (we_i),
      .adr_i                  (adr_i),
      .sel_i                  (sel_i),
      .dat_i                  (dat_i),
      .dat_o                  (dat_o),
      .ack_o                  (ack_o),
      .err_o                  (err_o),
      .volume_step_input_i    (volume_step_input_i),
      .power_down_i           (power_down_i),
      .speaker_active_i       (speaker_active_i),
      .aux_active_i           (aux_active_i),
      .pwm_pos_i              (pwm_pos_i),
      .pwm_neg_i              (pwm_neg_i),
      .speaker_drive_pos_o    (speaker_drive_pos_o),
      .speaker_drive_pos_oe_o (speaker_drive_pos_oe_o),
      .speaker_drive_neg_o    (speaker_drive_neg_o),
      .speaker_drive_neg_oe_o (speaker_drive_neg_oe_o),
      .aux_voltage_mode_o     (aux_voltage_mode_o),
      .aux_power_on_o         (aux_power_on_o),
      .aux_current_output_o   (aux_current_output_o),
      .volume_level_o         (volume_level_o)
   );
   opv_button u_opv_button (.clk_i(clk_i), .press_i(press), .line_o(volume_step_input_i));
   assign pwm_neg_i = !pwm_pos_i;
   initial forever #20 clk_i = !clk_i;
   always @(posedge clk_i) pwm_pos_i <= !pwm_pos_i;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
      q = dat_o;
      e = err_o;
      if (n >= 20) chk(n, 0);
      cyc_i <= 0;
      stb_i <= 0;
      @(posedge clk_i);
   endtask
   // hold the button down n cycles, then leave it released long enough to settle
   task automatic step(input int n);
      press <= 1;
      wait_n(n);
      press <= 0;
      wait_n(12);
   endtask
   task automatic t_reset;
      wb(0, 4'h0, 0);
      chk(q, 32'h0000_0107);
      chk(volume_level_o, 7);
      chk({aux_power_on_o, aux_voltage_mode_o}, 2'b10);
      wb(0, 4'hc, 0);
      chk(e, 1);
      $display("t_reset done");
   endtask
   task automatic t_sweep;
      logic up;
      up = 0;
      v = 7;
      repeat (15) begin
         step(12);
         if (v == 3'h0) up = 1;
         else if (v == 3'h7) up = 0;
         v = up ? v + 3'h1 : v - 3'h1;
         chk(volume_level_o, v);
      end
      step(2);
      chk(volume_level_o, v);
      $display("t_sweep done");
   endtask
   task automatic t_apc;
      wb(1, 4'h0, 32'h0000_0103);
      chk(volume_level_o, 3);
      wb(0, 4'h0, 0);
      chk(q, 32'h0000_0103);
      step(12);
      chk(volume_level_o, 2);
      wb(1, 4'h8, 5);
      wb(0, 4'h8, 0);
      chk(q, 32'h0000_0005);
      rst_i <= 1;
      wait_n(2);
      rst_i <= 0;
      wait_n(1);
      chk(volume_level_o, 5);
      // status after reset: volume 5, sweeping down, ramp idle, button released
      wb(0, 4'h4, 0);
      chk(q, 32'h0001_0005);
      $display("t_apc done");
   endtask
   task automatic t_spk;
      for (int i = 0; i < 8; i++) begin
         power_down_i <= i[0];
         speaker_active_i <= i[1];
         wb(1, 4'h0, {23'h0, i[2], 8'h07});
         wait_n(2);
         chk(speaker_drive_pos_oe_o, !i[0] && i[1] && i[2]);
         chk(speaker_drive_neg_oe_o, !i[0] && i[1] && i[2]);
         // pin data was registered from the pwm phase one cycle back
         chk(speaker_drive_pos_o, !i[0] && i[1] && i[2] && !pwm_pos_i);
         chk(speaker_drive_neg_o, !i[0] && i[1] && i[2] && pwm_pos_i);
      end
      // leave the device powered for the aux scenario
      power_down_i <= 0;
      wait_n(1);
      $display("t_spk done");
   endtask
   task automatic t_aux;
      wb(1, 4'h0, 32'h0000_0287);
      chk({aux_voltage_mode_o, aux_power_on_o}, 2'b10);
      wb(1, 4'h0, 32'h0000_0107);
      aux_active_i <= 1;
      wait_n(40);
      chk(aux_current_output_o > 8'h00 && aux_current_output_o < 8'hff, 1);
      wait_n(600);
      chk(aux_current_output_o, 8'hff);
      aux_active_i <= 0;
      wait_n(600);
      chk(aux_current_output_o, 0);
      $display("t_aux done");
   endtask
   initial begin
      wait_n(6);
      rst_i <= 0;
      wait_n(1);
      t_reset;
      t_sweep;
      t_apc;
      t_spk;
      t_aux;
      stop_test;
   end
   // the full sequence needs about 1700 cycles; allow over five times that
   initial begin
      #400000;
      n_fail++;
      stop_test;
   end
endmodule
`default_nettype wire
